// file: vtl_host_model.sv
// host model: whole-word reads and writes on the command port
`timescale 1ns/100ps
module vtl_host_model (
	// clock
	input  wire logic         clk_sys,
	// command port
	output logic              cmd_wr,
	output logic              cmd_rd,
	output vtl_pkg::vtl_word_s cmd_word,
	input  wire logic [15:0]  rd_data,
	input  wire logic         rd_valid
);
	import vtl_pkg::*;
	// idle at time zero
	initial begin
		cmd_wr = 1'b0;
		cmd_rd = 1'b0;
		cmd_word = '0;
	end
	// one pulse per word; the word is inverted after release so stale data never passes
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk_sys);
		cmd_word = '{c, d};
		cmd_wr = 1'b1;
		@(negedge clk_sys);
		cmd_wr = 1'b0;
		cmd_word = ~cmd_word;
	endtask
	// a read that never answers returns unknown, so the compare fails
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		int n;
		@(negedge clk_sys);
		cmd_word = '{c, 16'h0000};
		cmd_rd = 1'b1;
		@(negedge clk_sys);
		cmd_rd = 1'b0;
		cmd_word = ~cmd_word;
		d = 16'hXXXX;
		for (n = 0; n < 4 && rd_valid !== 1'b1; n++) begin
			@(negedge clk_sys);
		end
		if (rd_valid === 1'b1) begin
			d = rd_data;
		end
	endtask
endmodule // vtl_host_model

// file: vtl_pkg.sv
// package: command codes, fixed-point layout, limits and shared types of the trim/limit block
package vtl_pkg;
	// command codes of the three word registers
	localparam logic [7:0] CMD_OUTPUT_OFFSET_TRIM  = 8'h22;
	localparam logic [7:0] CMD_OUTPUT_CEILING      = 8'h24;
	localparam logic [7:0] CMD_UPPER_MARGIN_TARGET = 8'h25;
	// reset values; real parts reload these from backup storage after reset
	localparam logic [15:0] RST_OUTPUT_OFFSET_TRIM  = 16'h0000;
	localparam logic [15:0] RST_OUTPUT_CEILING      = 16'hFFFF;
	localparam logic [15:0] RST_UPPER_MARGIN_TARGET = 16'h0000;
	// internal target width; one lsb is 2^-12 V
	localparam int IW = 26;
	// output_number_format fields
	localparam int FMT_REL_BIT = 7;
	localparam int FMT_EXP_MSB = 4;
	// supported exponent range, -12 .. -4
	localparam logic signed [5:0] EXP_LOW  = -6'sd12;
	localparam logic signed [5:0] EXP_HIGH = -6'sd4;
	localparam logic [3:0] SHIFT_MAX = 4'h8;
	// valid target ceilings per feedback_scale_factor, in 2^-12 V units
	localparam logic signed [IW-1:0] SCALE_CEIL_1000 = 26'sh0000B33; // 0.700 V
	localparam logic signed [IW-1:0] SCALE_CEIL_0500 = 26'sh0001666; // 1.400 V
	localparam logic signed [IW-1:0] SCALE_CEIL_0250 = 26'sh0002CCC; // 2.800 V
	localparam logic signed [IW-1:0] SCALE_CEIL_0125 = 26'sh0006000; // 6.000 V
	// feedback_scale_factor select codes
	localparam logic [1:0] SCALE_1000 = 2'h0;
	localparam logic [1:0] SCALE_0500 = 2'h1;
	localparam logic [1:0] SCALE_0250 = 2'h2;
	localparam logic [1:0] SCALE_0125 = 2'h3;
	// margin field of the operation command that selects margin high
	localparam logic [1:0] MARGIN_HIGH = 2'h2;
	// backup byte of the trim, exponent -12
	localparam logic signed [IW-1:0] NVM_TRIM_MAX = 26'sh000007F;
	localparam logic signed [IW-1:0] NVM_TRIM_MIN = -26'sh0000080;
	// slew tick period
	localparam int CLK_NS      = 50;
	localparam int TICK_NS     = 1000;
	localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
	// one word command from the bus engine
	typedef struct packed {
		logic [7:0]  cmd;
		logic [15:0] data;
	} vtl_word_s;
	// sticky status bits
	typedef struct packed {
		logic none_above;
		logic word_vout;
		logic limit_warning_bit;
		logic invalid_data;
	} vtl_stat_s;
endpackage

// file: vtl_ramp.sv
// target ramp: steps the dac level toward its goal once per slew tick
`timescale 1ns/100ps
module vtl_ramp #(
	parameter int W = 26
) (
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rstn,
	// control
	input  wire logic                tick,
	input  wire logic                slew_en,
	input  wire logic signed [W-1:0] goal,
	input  wire logic [15:0]         step,
	// ramped level
	output logic signed [W-1:0]      level
);
	logic signed [W-1:0] stp;
	logic signed [W-1:0] diff;

	assign stp  = $signed({{(W-16){1'b0}}, step});
	assign diff = goal - level;

	// outside conversion the level follows at once; turn-on/off ramps belong elsewhere
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			level <= '0;
		end else if (!slew_en) begin
			level <= goal;
		end else if (tick) begin
			if (diff > stp) begin
				level <= level + stp;
			end else if (diff < -stp) begin
				level <= level - stp;
			end else begin
				level <= goal;
			end
		end
	end

	property p_ramp_hold;
		@(posedge clk_sys) disable iff (!rstn)
		(slew_en && !tick) |=> $stable(level);
	endproperty
	a_ramp_hold: assert property (p_ramp_hold) else $error("level moved between ticks");
endmodule // vtl_ramp

// file: vtl_tick.sv
// slew tick divider: one-cycle enable every CYCLES clocks
`timescale 1ns/100ps
module vtl_tick #(
	parameter int CYCLES = 20
) (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// enable pulse
	output logic      tick
);
	logic [15:0] cnt;

	// free-running count, tick on wrap
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cnt  <= 16'h0000;
			tick <= 1'b0;
		end else if (cnt == 16'(CYCLES - 1)) begin
			cnt  <= 16'h0000;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 16'h0001;
			tick <= 1'b0;
		end
	end

	property p_tick_single;
		@(posedge clk_sys) disable iff (!rstn)
		tick |=> !tick;
	endproperty
	a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");
endmodule // vtl_tick

// file: vtl_trim_limit.sv
// offset trim, output ceiling and upper margin registers with target clamp and checks
`timescale 1ns/100ps
module vtl_trim_limit #(
	parameter int TICK_CYC = vtl_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic                          clk_sys,
	input  wire logic                          rstn,
	// word command port from the bus engine
	input  wire logic                          cmd_wr,
	input  wire logic                          cmd_rd,
	input  wire vtl_pkg::vtl_word_s            cmd_word,
	output logic [15:0]                        rd_data,
	output logic                               rd_valid,
	output logic                               rd_hit,
	// operating inputs from the rest of the controller
	input  wire logic [15:0]                   output_setpoint,
	input  wire logic [15:0]                   output_floor,
	input  wire logic [7:0]                    output_number_format,
	input  wire logic [1:0]                    feedback_scale_factor,
	input  wire logic [1:0]                    op_margin,
	input  wire logic                          conv_en,
	input  wire logic signed [vtl_pkg::IW-1:0] dac_max,
	input  wire logic [15:0]                   slew_step,
	input  wire logic                          clear_status,
	// results
	output logic signed [vtl_pkg::IW-1:0]      dac_target,
	output vtl_pkg::vtl_stat_s                 status,
	output logic                               host_notify,
	output logic [7:0]                         nvm_trim_byte
);
	import vtl_pkg::*;

	logic [15:0]          output_offset_trim;
	logic [15:0]          output_ceiling;
	logic [15:0]          upper_margin_target;
	logic [3:0]           shift;
	logic signed [5:0]    expo;
	logic                 rel;
	logic signed [IW-1:0] trim_i;
	logic signed [IW-1:0] set_i;
	logic signed [IW-1:0] floor_i;
	logic signed [IW-1:0] ceil_i;
	logic signed [IW-1:0] marg_i;
	logic signed [IW-1:0] scale_ceil;
	logic signed [IW-1:0] base_i;
	logic signed [IW-1:0] raw;
	logic signed [IW-1:0] next_tgt;
	logic                 viol;
	logic signed [IW-1:0] cand_trim;
	logic signed [IW-1:0] cand_marg;
	logic                 wr_trim;
	logic                 wr_ceil;
	logic                 wr_marg;
	logic                 trim_bad;
	logic                 marg_bad;
	logic signed [IW-1:0] tgt_q;
	logic signed [IW-1:0] raw_q;
	logic signed [IW-1:0] ceil_q;
	logic                 viol_q;
	logic                 wr_done_q;
	logic                 warn_evt;
	logic                 tick;

	// converts a word at the current exponent to 2^-12 V units
	function automatic logic signed [IW-1:0] to_int(input logic [15:0] v, input logic sgn,
		input logic [3:0] sh);
		logic signed [IW-1:0] x;
		x = sgn ? $signed({{(IW-16){v[15]}}, v}) : $signed({{(IW-16){1'b0}}, v});
		return x <<< sh;
	endfunction

	// exponent from the format byte; unsupported codes clip to the nearest end
	always_comb begin
		expo = {output_number_format[FMT_EXP_MSB], output_number_format[FMT_EXP_MSB:0]};
		if (expo < EXP_LOW) begin
			shift = 4'h0;
		end else if (expo > EXP_HIGH) begin
			shift = SHIFT_MAX;
		end else begin
			shift = 4'(expo - EXP_LOW);
		end
	end

	// operands in common units
	assign rel     = output_number_format[FMT_REL_BIT];
	assign trim_i  = to_int(output_offset_trim, 1'b1, shift);
	assign set_i   = to_int(output_setpoint, 1'b0, shift);
	assign floor_i = to_int(output_floor, 1'b0, shift);
	assign ceil_i  = to_int(output_ceiling, 1'b0, shift);
	// relative margin is a signed offset from the setpoint
	assign marg_i  = rel ? set_i + to_int(upper_margin_target, 1'b1, shift)
		: to_int(upper_margin_target, 1'b0, shift);

	// valid range ceiling from the loop scale
	always_comb begin
		unique case (feedback_scale_factor)
			SCALE_1000: scale_ceil = SCALE_CEIL_1000;
			SCALE_0500: scale_ceil = SCALE_CEIL_0500;
			SCALE_0250: scale_ceil = SCALE_CEIL_0250;
			SCALE_0125: scale_ceil = SCALE_CEIL_0125;
		endcase
	end

	// base selection and sum
	assign base_i = (op_margin == MARGIN_HIGH) ? marg_i : set_i;
	assign raw    = base_i + trim_i;

	// clamp chain: ceiling and floor warn, dac maximum does not
	always_comb begin
		viol     = 1'b0;
		next_tgt = raw;
		if (raw > ceil_i) begin
			next_tgt = ceil_i;
			viol     = 1'b1;
		end else if (raw < floor_i) begin
			next_tgt = floor_i;
			viol     = 1'b1;
		end
		if (next_tgt > dac_max) begin
			next_tgt = dac_max;
		end
		if (next_tgt < 0) begin
			next_tgt = '0;
		end
	end

	// write decode; host is trusted to send whole words
	assign wr_trim = cmd_wr && (cmd_word.cmd == CMD_OUTPUT_OFFSET_TRIM);
	assign wr_ceil = cmd_wr && (cmd_word.cmd == CMD_OUTPUT_CEILING);
	assign wr_marg = cmd_wr && (cmd_word.cmd == CMD_UPPER_MARGIN_TARGET);

	// candidate targets for incoming data, checked against the scale range
	assign cand_trim = base_i + to_int(cmd_word.data, 1'b1, shift);
	assign cand_marg = (rel ? set_i + to_int(cmd_word.data, 1'b1, shift)
		: to_int(cmd_word.data, 1'b0, shift)) + trim_i;
	assign trim_bad  = (cand_trim < 0) || (cand_trim > scale_ceil);
	assign marg_bad  = (cand_marg < 0) || (cand_marg > scale_ceil);

	// trim register; rejected data leaves the old value
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			output_offset_trim <= RST_OUTPUT_OFFSET_TRIM;
		end else if (wr_trim && !trim_bad) begin
			output_offset_trim <= cmd_word.data;
		end
	end

	// ceiling register, absolute whatever the format says
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			output_ceiling <= RST_OUTPUT_CEILING;
		end else if (wr_ceil) begin
			output_ceiling <= cmd_word.data;
		end
	end

	// upper margin register
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			upper_margin_target <= RST_UPPER_MARGIN_TARGET;
		end else if (wr_marg && !marg_bad) begin
			upper_margin_target <= cmd_word.data;
		end
	end

	// read port: one cycle after the request; unmapped codes answer zero, no hit
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
			rd_hit   <= 1'b0;
		end else begin
			rd_valid <= cmd_rd;
			if (cmd_rd) begin
				unique case (cmd_word.cmd)
					CMD_OUTPUT_OFFSET_TRIM: begin
						rd_data <= output_offset_trim;
						rd_hit  <= 1'b1;
					end
					CMD_OUTPUT_CEILING: begin
						rd_data <= output_ceiling;
						rd_hit  <= 1'b1;
					end
					CMD_UPPER_MARGIN_TARGET: begin
						rd_data <= upper_margin_target;
						rd_hit  <= 1'b1;
					end
					default: begin
						rd_data <= 16'h0000;
						rd_hit  <= 1'b0;
					end
				endcase
			end
		end
	end

	// target pipeline, recomputed every cycle so any input change lands
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			tgt_q     <= '0;
			raw_q     <= '0;
			ceil_q    <= '0;
			viol_q    <= 1'b0;
			wr_done_q <= 1'b0;
		end else begin
			tgt_q     <= next_tgt;
			raw_q     <= raw;
			ceil_q    <= ceil_i;
			viol_q    <= viol;
			wr_done_q <= wr_trim | wr_ceil | wr_marg;
		end
	end

	// a new violating target warns once; a write also warns when not converting
	assign warn_evt = viol && (conv_en || wr_done_q)
		&& (!viol_q || (raw != raw_q) || (ceil_i != ceil_q));

	// sticky status; a set in the clearing cycle wins
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			status <= '0;
		end else begin
			if (warn_evt) begin
				status.none_above        <= 1'b1;
				status.word_vout         <= 1'b1;
				status.limit_warning_bit <= 1'b1;
			end else if (clear_status) begin
				status.none_above        <= 1'b0;
				status.word_vout         <= 1'b0;
				status.limit_warning_bit <= 1'b0;
			end
			if ((wr_trim && trim_bad) || (wr_marg && marg_bad)) begin
				status.invalid_data <= 1'b1;
			end else if (clear_status) begin
				status.invalid_data <= 1'b0;
			end
		end
	end

	// host notification pulse for either kind of event
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			host_notify <= 1'b0;
		end else begin
			host_notify <= warn_evt || (wr_trim && trim_bad) || (wr_marg && marg_bad);
		end
	end

	// backup byte at exponent -12, saturated so the restore never wraps
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			nvm_trim_byte <= 8'h00;
		end else if (trim_i > NVM_TRIM_MAX) begin
			nvm_trim_byte <= 8'h7F;
		end else if (trim_i < NVM_TRIM_MIN) begin
			nvm_trim_byte <= 8'h80;
		end else begin
			nvm_trim_byte <= trim_i[7:0];
		end
	end

	// slew tick and ramp toward the clamped target
	vtl_tick #(
		.CYCLES (TICK_CYC)
	) u_tick (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.tick    (tick)
	);

	vtl_ramp #(
		.W (IW)
	) u_ramp (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.tick    (tick),
		.slew_en (conv_en),
		.goal    (tgt_q),
		.step    (slew_step),
		.level   (dac_target)
	);

	property p_trim_store;
		@(posedge clk_sys) disable iff (!rstn)
		(wr_trim && !trim_bad) |=> (output_offset_trim == $past(cmd_word.data));
	endproperty
	a_trim_store: assert property (p_trim_store) else $error("trim not stored");

	property p_trim_reject;
		@(posedge clk_sys) disable iff (!rstn)
		(wr_trim && trim_bad) |=> ($stable(output_offset_trim) && status.invalid_data && host_notify);
	endproperty
	a_trim_reject: assert property (p_trim_reject) else $error("bad trim not rejected");

	property p_ceil_store;
		@(posedge clk_sys) disable iff (!rstn)
		wr_ceil |=> (output_ceiling == $past(cmd_word.data));
	endproperty
	a_ceil_store: assert property (p_ceil_store) else $error("ceiling not stored");

	property p_ceil_clamp;
		@(posedge clk_sys) disable iff (!rstn)
		(raw > ceil_i && ceil_i <= dac_max && ceil_i >= 0) |=> (tgt_q == $past(ceil_i));
	endproperty
	a_ceil_clamp: assert property (p_ceil_clamp) else $error("target above ceiling");

	property p_dac_quiet;
		@(posedge clk_sys) disable iff (!rstn)
		(raw > dac_max && raw <= ceil_i && raw >= floor_i && dac_max >= 0)
			|=> (tgt_q == $past(dac_max));
	endproperty
	a_dac_quiet: assert property (p_dac_quiet) else $error("dac maximum clamp wrong");

	property p_dac_no_warn;
		@(posedge clk_sys) disable iff (!rstn)
		(raw > dac_max && raw <= ceil_i && raw >= floor_i) |-> !warn_evt;
	endproperty
	a_dac_no_warn: assert property (p_dac_no_warn) else $error("warning on dac clamp");

	property p_warn_status;
		@(posedge clk_sys) disable iff (!rstn)
		warn_evt |=> (status.none_above && status.word_vout && status.limit_warning_bit
			&& host_notify);
	endproperty
	a_warn_status: assert property (p_warn_status) else $error("violation status missing");

	property p_margin_high;
		@(posedge clk_sys) disable iff (!rstn)
		(op_margin == MARGIN_HIGH && !viol && marg_i + trim_i <= dac_max && marg_i + trim_i >= 0)
			|=> (tgt_q == $past(marg_i) + $past(trim_i));
	endproperty
	a_margin_high: assert property (p_margin_high) else $error("margin target wrong");

	property p_nvm_sat;
		@(posedge clk_sys) disable iff (!rstn)
		(trim_i > NVM_TRIM_MAX) |=> (nvm_trim_byte == 8'h7F);
	endproperty
	a_nvm_sat: assert property (p_nvm_sat) else $error("backup byte not saturated");
endmodule // vtl_trim_limit

// file: vtl_trim_limit_tb_top.sv
// self-checking bench for the trim, ceiling and upper margin registers
`timescale 1ns/100ps
module vtl_trim_limit_tb_top;
	import vtl_pkg::*;
	logic                 clk_sys;
	logic                 rstn;
	logic                 cmd_wr;
	logic                 cmd_rd;
	vtl_word_s            cmd_word;
	logic [15:0]          rd_data;
	logic                 rd_valid;
	logic                 rd_hit;
	logic [15:0]          output_setpoint;
	logic [15:0]          output_floor;
	logic [7:0]           output_number_format;
	logic [1:0]           feedback_scale_factor;
	logic [1:0]           op_margin;
	logic                 conv_en;
	logic signed [IW-1:0] dac_max;
	logic [15:0]          slew_step;
	logic                 clear_status;
	logic signed [IW-1:0] dac_target;
	vtl_stat_s            status;
	logic                 host_notify;
	logic [7:0]           nvm_trim_byte;
	int                   n_fail = 0;
	int                   num_checks = 0;
	int                   n_note = 0;
	int                   n0;
	int                   cyc = 0;
	logic [15:0]          rv;
	logic [15:0]          ceil_tab [4] = '{16'h0B33, 16'h1666, 16'h2CCC, 16'h6000};
	logic [15:0]          trim_tab [3] = '{16'h0010, 16'hFF00, 16'h0100};
	logic [25:0]          dac_tab [3] = '{26'h1010, 26'h0F00, 26'h1100};
	logic [7:0]           nvm_tab [3] = '{8'h10, 8'h80, 8'h7F};

	// short tick so ramps finish in a few cycles
	vtl_trim_limit #(.TICK_CYC(2)) dut (.clk_sys(clk_sys), .rstn(rstn), .cmd_wr(cmd_wr),
		.cmd_rd(cmd_rd), .cmd_word(cmd_word), .rd_data(rd_data), .rd_valid(rd_valid),
		.rd_hit(rd_hit), .output_setpoint(output_setpoint), .output_floor(output_floor),
		.output_number_format(output_number_format),
		.feedback_scale_factor(feedback_scale_factor), .op_margin(op_margin),
		.conv_en(conv_en), .dac_max(dac_max), .slew_step(slew_step),
		.clear_status(clear_status), .dac_target(dac_target), .status(status),
		.host_notify(host_notify), .nvm_trim_byte(nvm_trim_byte));
	vtl_host_model u_host (.clk_sys(clk_sys), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
		.cmd_word(cmd_word), .rd_data(rd_data), .rd_valid(rd_valid));

	// clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// notify pulses last one cycle; count them mid-cycle, where they have settled
	always @(negedge clk_sys) begin
		if (host_notify === 1'b1) begin
			n_note++;
		end
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic rchk(input logic [7:0] c, input logic [15:0] e);
		u_host.rd(c, rv);
		chk("read", rv, e);
	endtask
	// long enough for the ramp to land at the short tick
	task automatic dchk(input logic [25:0] e);
		wt(10);
		chk("dac", {6'h00, dac_target}, {6'h00, e});
	endtask
	task automatic clr;
		clear_status = 1'b1;
		wt(1);
		clear_status = 1'b0;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		rstn = 1'b0;
		output_setpoint = 16'h1000;
		output_floor = 16'h0000;
		output_number_format = 8'h14;
		feedback_scale_factor = SCALE_0125;
		op_margin = 2'h0;
		conv_en = 1'b0;
		dac_max = 26'sh0007000;
		slew_step = 16'h7FFF;
		clear_status = 1'b0;
		wt(6);
		rstn = 1'b1;
		// reset values and an unmapped code
		rchk(CMD_OUTPUT_OFFSET_TRIM, 16'h0000);
		rchk(CMD_OUTPUT_CEILING, 16'hFFFF);
		rchk(CMD_UPPER_MARGIN_TARGET, 16'h0000);
		chk("hit", rd_hit, 1'b1);
		rchk(8'h21, 16'h0000);
		chk("hit", rd_hit, 1'b0);
		$display("test reset done");
		// trim adds to setpoint, backup byte saturates
		for (int i = 0; i < 3; i++) begin
			u_host.wr(CMD_OUTPUT_OFFSET_TRIM, trim_tab[i]);
			dchk(dac_tab[i]);
			chk("nvm", nvm_trim_byte, nvm_tab[i]);
			rchk(CMD_OUTPUT_OFFSET_TRIM, trim_tab[i]);
		end
		// coarser exponent scales both words; out-of-range exponent clips
		output_number_format = 8'h18;
		output_setpoint = 16'h0100;
		u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'h0001);
		dchk(26'h1010);
		chk("nvm", nvm_trim_byte, 8'h10);
		output_number_format = 8'h10;
		dchk(26'h0101);
		// exponent above the coarsest end clips to shift 8
		output_number_format = 8'h1E;
		output_setpoint = 16'h0010;
		dchk(26'h1100);
		output_number_format = 8'h14;
		output_setpoint = 16'h1000;
		$display("test trim done");
		// boundary of the valid window at each scale
		for (int s = 0; s < 4; s++) begin
			feedback_scale_factor = 2'(s);
			output_setpoint = ceil_tab[s] - 16'h0010;
			u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'h0010);
			rchk(CMD_OUTPUT_OFFSET_TRIM, 16'h0010);
			n0 = n_note;
			u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'h0011);
			wt(2);
			rchk(CMD_OUTPUT_OFFSET_TRIM, 16'h0010);
			chk("status", status, 4'b0001);
			chk("notify", n_note - n0, 1);
			clr();
		end
		output_setpoint = 16'h0010;
		u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'hFFEF);
		rchk(CMD_OUTPUT_OFFSET_TRIM, 16'h0010);
		chk("status", status, 4'b0001);
		clr();
		$display("test validity done");
		// above dac hardware but under ceiling: silent clamp
		dac_max = 26'sh0001800;
		output_setpoint = 16'h2000;
		u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'h0000);
		dchk(26'h1800);
		chk("status", status, 4'b0000);
		dac_max = 26'sh0007000;
		$display("test dac clamp done");
		// ceiling written below the running target
		conv_en = 1'b1;
		wt(10);
		n0 = n_note;
		u_host.wr(CMD_OUTPUT_CEILING, 16'h1800);
		dchk(26'h1800);
		chk("status", status, 4'b1110);
		chk("notify", n_note - n0, 1);
		rchk(CMD_OUTPUT_CEILING, 16'h1800);
		output_number_format = 8'h94;
		u_host.wr(CMD_OUTPUT_CEILING, 16'h1700);
		dchk(26'h1700);
		output_number_format = 8'h14;
		u_host.wr(CMD_OUTPUT_CEILING, 16'hFFFF);
		// trim pushes the target under the floor
		output_setpoint = 16'h1000;
		output_floor = 16'h1000;
		wt(10);
		clr();
		u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'hFF00);
		dchk(26'h1000);
		chk("status", status, 4'b1110);
		output_floor = 16'h0000;
		u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'h0000);
		clr();
		$display("test limits done");
		// small step: the move takes several ticks while converting
		wt(10);
		slew_step = 16'h0010;
		u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'h0040);
		wt(2);
		chk("ramping", dac_target < 26'sh0001040, 1'b1);
		dchk(26'h1040);
		conv_en = 1'b0;
		u_host.wr(CMD_OUTPUT_OFFSET_TRIM, 16'h0010);
		wt(3);
		chk("dac", {6'h00, dac_target}, 32'h00001010);
		$display("test slew done");
		// margin high, absolute then relative, then refused and capped
		op_margin = MARGIN_HIGH;
		u_host.wr(CMD_UPPER_MARGIN_TARGET, 16'h1400);
		dchk(26'h1410);
		rchk(CMD_UPPER_MARGIN_TARGET, 16'h1400);
		output_number_format = 8'h94;
		u_host.wr(CMD_UPPER_MARGIN_TARGET, 16'h0100);
		dchk(26'h1110);
		output_number_format = 8'h14;
		u_host.wr(CMD_UPPER_MARGIN_TARGET, 16'h7000);
		wt(2);
		rchk(CMD_UPPER_MARGIN_TARGET, 16'h0100);
		chk("status", status, 4'b0001);
		clr();
		u_host.wr(CMD_OUTPUT_CEILING, 16'h1800);
		u_host.wr(CMD_UPPER_MARGIN_TARGET, 16'h1900);
		dchk(26'h1800);
		chk("status", status, 4'b1110);
		$display("test margin done");
		summarize();
	end
endmodule // vtl_trim_limit_tb_top
